// [design/codec_port_status.sv]
// Function
// (R1) Underrun of empty telecom transmit FIFO sets bit 6 and interrupts.
// (R2) Overrun of full telecom receive FIFO sets bit 7 and interrupts.
// (R3) Bit 8 is one while audio transmit FIFO is not full.
// (R4) Bit 9 is one while audio receive FIFO is not empty.
// (R5) Bit 10 is one while telecom transmit FIFO is not full.
// (R6) Bit 11 is one while telecom receive FIFO is not empty.
// (R7) Bit 12 sets when a codec register write has completed.
// (R8) Bit 13 sets when codec read data lands in data register.
// (R9) Bit 14 shows audio input or output enable in codec.
// (R10) Bit 15 shows telecom input or output enable in codec.
// (R11) Any data register access clears bits 12 and 13; a done event in the same cycle keeps its bit set.
// (R12) Writes to read-only and reserved bits ignored; reserved reads zero.
// (R13) Software clears set status bits before enabling the port.
// (R14) Error flags hold until written one; interrupt stays while set.
//
// Design decisions made here: the APB register port and the register addresses.
module codec_port_status (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Telecom FIFO error events, one-cycle pulses
	input wire logic tel_tx_underrun_evt,
	input wire logic tel_rx_overrun_evt,
	// FIFO levels
	input wire logic aud_tx_full,
	input wire logic aud_rx_empty,
	input wire logic tel_tx_full,
	input wire logic tel_rx_empty,
	// Codec register traffic
	input wire logic codec_wr_done_evt,
	input wire logic codec_rd_done_evt,
	input wire logic codec_data_access,
	// Codec control register B enable bits
	input wire logic aud_in_ena,
	input wire logic aud_out_ena,
	input wire logic tel_in_ena,
	input wire logic tel_out_ena,
	// Interrupt
	output logic irq
);

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic setup_ph;
	logic access_ph;
	logic hit_status;
	logic hit_mask;
	logic hit_any;
	logic wr_strobe;
	logic status_w1c;
	logic mask_wr;

	// Zero wait states: every access finishes in its first access cycle
	assign setup_ph = psel && !penable;
	assign access_ph = psel && penable;
	assign hit_status = (paddr == codec_status_pkg::STATUS_OFF);
	assign hit_mask = (paddr == codec_status_pkg::MASK_OFF);
	assign hit_any = hit_status || hit_mask;
	assign wr_strobe = access_ph && pwrite;
	assign status_w1c = wr_strobe && hit_status;
	assign mask_wr = wr_strobe && hit_mask;
	assign pready = 1'b1;
	assign pslverr = access_ph && !hit_any;

	// ------------------------------------------------------------
	// Sticky flags: 0 underrun, 1 overrun, 2 write done, 3 read done
	// ------------------------------------------------------------
	logic [3:0] flag_set;
	logic [3:0] flag_clr;
	logic [3:0] flag_q;
	logic clr_underrun;
	logic clr_overrun;

	// Only the two error bits accept write-one-to-clear
	assign clr_underrun = status_w1c &&
		pwdata[codec_status_pkg::UNDERRUN_BIT]; // R14
	assign clr_overrun = status_w1c &&
		pwdata[codec_status_pkg::OVERRUN_BIT]; // R14

	// Event sources for each flag
	assign flag_set[0] = tel_tx_underrun_evt; // R1
	assign flag_set[1] = tel_rx_overrun_evt; // R2
	assign flag_set[2] = codec_wr_done_evt; // R7
	assign flag_set[3] = codec_rd_done_evt; // R8

	// Completion flags clear on data register access, not by software
	assign flag_clr[0] = clr_underrun;
	assign flag_clr[1] = clr_overrun;
	assign flag_clr[2] = codec_data_access; // R11
	assign flag_clr[3] = codec_data_access; // R11

	// One flag cell per bit, joined by the control interface
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_flag
			sticky_ctl_if ctl();
			assign ctl.set = flag_set[gi];
			assign ctl.clr = flag_clr[gi];
			assign flag_q[gi] = ctl.q;
			sticky_flag u_flag (
				.pclk(pclk),
				.presetn(presetn),
				.f(ctl)
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Level flags
	// ------------------------------------------------------------
	logic [5:0] lvl_raw;
	logic [5:0] lvl_q;
	logic aud_en_raw;
	logic tel_en_raw;

	// Either direction enabled counts as path enabled
	assign aud_en_raw = aud_in_ena || aud_out_ena; // R9
	assign tel_en_raw = tel_in_ena || tel_out_ena; // R10

	// Not-full and not-empty senses are inverted from the FIFO side
	assign lvl_raw[0] = !aud_tx_full; // R3
	assign lvl_raw[1] = !aud_rx_empty; // R4
	assign lvl_raw[2] = !tel_tx_full; // R5
	assign lvl_raw[3] = !tel_rx_empty; // R6
	assign lvl_raw[4] = aud_en_raw;
	assign lvl_raw[5] = tel_en_raw;

	level_flags u_lvl (
		.pclk(pclk),
		.presetn(presetn),
		.raw(lvl_raw),
		.q(lvl_q)
	);

	// ------------------------------------------------------------
	// Mask and interrupt
	// ------------------------------------------------------------
	logic [1:0] mask_r;
	logic [1:0] mask_nxt;
	logic irq_r;
	logic irq_nxt;

	// Reset unmasked so errors interrupt without setup
	assign mask_nxt = mask_wr ?
		pwdata[codec_status_pkg::OVERRUN_BIT:
		codec_status_pkg::UNDERRUN_BIT] :
		mask_r;
	assign irq_nxt = |(flag_q[1:0] & mask_r); // R14
	assign irq = irq_r;

	// Mask register and registered interrupt level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_r <= codec_status_pkg::MASK_RST;
			irq_r <= 1'b0;
		end else begin
			mask_r <= mask_nxt;
			irq_r <= irq_nxt;
		end
	end

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	logic [31:0] status_word;
	logic [31:0] mask_word;
	logic [31:0] rd_sel;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;

	// Reserved bits 31..16 and lower service bits read as zero
	assign status_word = {16'h0000, lvl_q[5], lvl_q[4], flag_q[3],
		flag_q[2], lvl_q[3], lvl_q[2], lvl_q[1], lvl_q[0],
		flag_q[1], flag_q[0], 6'h00}; // R12
	assign mask_word = {24'h000000, mask_r, 6'h00};
	assign rd_sel = hit_status ? status_word :
		(hit_mask ? mask_word : 32'h00000000);
	assign prdata_nxt = (setup_ph && !pwrite) ? rd_sel : prdata_r;
	assign prdata = prdata_r;

	// Read data captured in the setup cycle, held through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h00000000;
		end else begin
			prdata_r <= prdata_nxt;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Event reaches the status word one edge later
	a_underrun_sets: assert property ( // R1
		tel_tx_underrun_evt |=> status_word[6])
		else $error("underrun flag not set");

	a_overrun_sets: assert property ( // R2
		tel_rx_overrun_evt |=> status_word[7] and (mask_r[1] |=> irq))
		else $error("overrun flag or interrupt missing");

	a_aud_tx_level: assert property ( // R3
		aud_tx_full |=> !status_word[8])
		else $error("audio not-full wrong");

	a_aud_rx_level: assert property ( // R4
		!aud_rx_empty |=> status_word[9])
		else $error("audio not-empty wrong");

	a_tel_tx_level: assert property ( // R5
		!tel_tx_full |=> status_word[10])
		else $error("telecom not-full wrong");

	a_tel_rx_level: assert property ( // R6
		tel_rx_empty |=> !status_word[11])
		else $error("telecom not-empty wrong");

	a_wr_done_sets: assert property ( // R7
		codec_wr_done_evt |=> status_word[12])
		else $error("write done not set");

	a_rd_done_sets: assert property ( // R8
		codec_rd_done_evt |=> status_word[13])
		else $error("read done not set");

	a_audio_enable: assert property ( // R9
		!aud_in_ena && !aud_out_ena |=> !status_word[14])
		else $error("audio enable wrong");

	a_tel_enable: assert property ( // R10
		(tel_in_ena || tel_out_ena) |=> status_word[15])
		else $error("telecom enable wrong");

	a_access_clears: assert property ( // R11
		codec_data_access && !codec_wr_done_evt && !codec_rd_done_evt
		|=> !status_word[12] && !status_word[13])
		else $error("done flags not cleared");

	a_reserved_zero: assert property ( // R12
		access_ph && !pwrite |-> prdata[31:16] == 16'h0000)
		else $error("reserved bits not zero");

	a_ro_write_ignored: assert property ( // R12
		status_w1c && !codec_data_access && !codec_wr_done_evt
		&& status_word[12] |=> status_word[12])
		else $error("read-only bit changed by write");

	a_error_holds: assert property ( // R14
		status_word[6] && !clr_underrun |=> status_word[6])
		else $error("underrun flag dropped");

	a_irq_follows: assert property ( // R14
		status_word[7] && mask_r[1] && !clr_overrun
		|=> irq ##0 status_word[7])
		else $error("interrupt not held");

	a_aud_tx_room: assert property ( // R3
		!aud_tx_full |=> status_word[8])
		else $error("audio not-full not raised");

	a_aud_rx_idle: assert property ( // R4
		aud_rx_empty |=> !status_word[9])
		else $error("audio not-empty not dropped");

	a_tel_tx_stop: assert property ( // R5
		tel_tx_full |=> !status_word[10])
		else $error("telecom not-full not dropped");

	a_tel_rx_data: assert property ( // R6
		!tel_rx_empty |=> status_word[11])
		else $error("telecom not-empty not raised");

	a_audio_on: assert property ( // R9
		(aud_in_ena || aud_out_ena) |=> status_word[14])
		else $error("audio enable not shown");

	a_tel_off: assert property ( // R10
		!tel_in_ena && !tel_out_ena |=> !status_word[15])
		else $error("telecom enable stuck");

	a_underrun_irq: assert property ( // R1
		tel_tx_underrun_evt ##1 mask_r[0] |=> irq)
		else $error("underrun interrupt missing");

	a_underrun_quiet: assert property ( // R1
		!status_word[6] && !tel_tx_underrun_evt |=> !status_word[6])
		else $error("underrun flag set with no event");

	a_overrun_quiet: assert property ( // R2
		!status_word[7] && !tel_rx_overrun_evt |=> !status_word[7])
		else $error("overrun flag set with no event");

	a_underrun_clears: assert property ( // R14
		clr_underrun && !tel_tx_underrun_evt |=> !status_word[6])
		else $error("underrun flag not cleared");

	a_overrun_clears: assert property ( // R14
		clr_overrun && !tel_rx_overrun_evt |=> !status_word[7])
		else $error("overrun flag not cleared");

	a_overrun_holds: assert property ( // R14
		status_word[7] && !clr_overrun |=> status_word[7])
		else $error("overrun flag dropped");

	a_irq_masked: assert property ( // R14
		!(status_word[6] && mask_r[0])
		&& !(status_word[7] && mask_r[1]) |=> !irq)
		else $error("interrupt with no unmasked flag");

	a_mask_irq_off: assert property ( // R14
		mask_r == 2'b00 |=> !irq)
		else $error("interrupt while fully masked");

	a_mask_write: assert property ( // R14
		mask_wr |=> mask_r == $past(pwdata[7:6]))
		else $error("mask write lost");

	a_wr_done_holds: assert property ( // R7
		status_word[12] && !codec_data_access |=> status_word[12])
		else $error("write done dropped");

	a_wr_done_quiet: assert property ( // R7
		!status_word[12] && !codec_wr_done_evt |=> !status_word[12])
		else $error("write done set with no write");

	a_rd_done_holds: assert property ( // R8
		status_word[13] && !codec_data_access |=> status_word[13])
		else $error("read done dropped");

	a_rd_done_quiet: assert property ( // R8
		!status_word[13] && !codec_rd_done_evt |=> !status_word[13])
		else $error("read done set with no read");

	a_rd_write_ignored: assert property ( // R12
		status_w1c && !codec_data_access && !codec_rd_done_evt
		&& status_word[13] |=> status_word[13])
		else $error("read done changed by write");

	a_status_read: assert property ( // R12
		setup_ph && !pwrite && hit_status
		|=> prdata == $past(status_word))
		else $error("status read data wrong");

	a_unmapped_read: assert property ( // R12
		setup_ph && !pwrite && !hit_any |=> prdata == 32'h00000000)
		else $error("unmapped read not zero");

endmodule : codec_port_status

// [shared/codec_status_pkg.sv]
package codec_status_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam logic [11:0] STATUS_OFF = 12'h018;
	localparam logic [11:0] MASK_OFF = 12'h01c;

	// ------------------------------------------------------------
	// Status field positions
	// ------------------------------------------------------------
	localparam int UNDERRUN_BIT = 6;
	localparam int OVERRUN_BIT = 7;
	localparam int AUD_NOT_FULL_BIT = 8;
	localparam int AUD_NOT_EMPTY_BIT = 9;
	localparam int TEL_NOT_FULL_BIT = 10;
	localparam int TEL_NOT_EMPTY_BIT = 11;
	localparam int WDONE_BIT = 12;
	localparam int RDONE_BIT = 13;
	localparam int AUDEN_BIT = 14;
	localparam int TELEN_BIT = 15;

	// ------------------------------------------------------------
	// Level flag order and reset values
	// ------------------------------------------------------------
	localparam int LVL_N = 6;
	// Order from bit 5: tel_en, aud_en, tel_rx, tel_tx, aud_rx, aud_tx
	localparam logic [5:0] LVL_RST = 6'h05;
	localparam logic [1:0] MASK_RST = 2'h3;
	localparam logic FLAG_RST = 1'b0;

endpackage : codec_status_pkg

// [shared/sticky_ctl_if.sv]
interface sticky_ctl_if;
	logic set;
	logic clr;
	logic q;
	modport owner(input set, input clr, output q);
	modport user(output set, output clr, input q);
endinterface : sticky_ctl_if

// [design/sticky_flag.sv]
module sticky_flag (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Flag control
	sticky_ctl_if.owner f
);

	logic q_r;
	logic q_nxt;

	// Set beats clear so an event in the clear cycle survives
	assign q_nxt = f.set ? 1'b1 : (f.clr ? 1'b0 : q_r);
	assign f.q = q_r;

	// Flag store
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_r <= codec_status_pkg::FLAG_RST;
		end else begin
			q_r <= q_nxt;
		end
	end

endmodule : sticky_flag

// [design/level_flags.sv]
module level_flags (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Live levels and their registered copy
	input wire logic [5:0] raw,
	output logic [5:0] q
);

	logic [5:0] q_r;

	assign q = q_r;

	// One register stage keeps status reads glitch free
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_r <= codec_status_pkg::LVL_RST;
		end else begin
			q_r <= raw;
		end
	end

endmodule : level_flags

// [testbench/codec_side_model.sv]
module codec_side_model (
	// Requested far-side state from the bench
	input wire logic [7:0] lv,
	input wire logic [4:0] ev,
	// FIFO levels: aud_tx_full, aud_rx_empty, tel_tx_full, tel_rx_empty
	output logic [3:0] fifo_lvl,
	// Codec enables: aud_in, aud_out, tel_in, tel_out
	output logic [3:0] ena,
	// One-cycle events
	output logic [4:0] evt
);
	timeunit 1ns;
	timeprecision 1ps;
	// Levels stand as long as the bench holds them
	assign fifo_lvl = lv[3:0];
	assign ena = lv[7:4];
	// Pulses: the bench clears them one edge later
	assign evt = ev;
endmodule : codec_side_model

// [testbench/tb_codec_port_status.sv]
module tb_codec_port_status;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed;
	logic [7:0] lv;
	logic [4:0] ev, evt;
	logic [3:0] fl, ena;
	logic [1:0] e_err, e_done;
	int n_mismatch = 0;
	int n_tests = 0;
	int cyc = 0;
	codec_side_model model (.lv(lv), .ev(ev), .fifo_lvl(fl), .ena(ena),
		.evt(evt));
	codec_port_status dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tel_tx_underrun_evt(evt[0]), .tel_rx_overrun_evt(evt[1]),
		.aud_tx_full(fl[0]), .aud_rx_empty(fl[1]), .tel_tx_full(fl[2]),
		.tel_rx_empty(fl[3]), .codec_wr_done_evt(evt[2]),
		.codec_rd_done_evt(evt[3]), .codec_data_access(evt[4]),
		.aud_in_ena(ena[0]), .aud_out_ena(ena[1]), .tel_in_ena(ena[2]),
		.tel_out_ena(ena[3]), .irq(irq));
	// 100 MHz clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// Hang guard, far above the few hundred cycles the tests need
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			end_sim();
		end
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	// Expected status word from bench-side state only
	function automatic logic [31:0] exp_st();
		return {16'h0000, lv[6] | lv[7], lv[4] | lv[5], e_done[1], e_done[0],
			~lv[3], ~lv[2], ~lv[1], ~lv[0], e_err, 6'h00};
	endfunction : exp_st
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	// APB transfer; request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the hang guard ends a wait that never sees pready
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd_st();
		apb(1'b0, codec_status_pkg::STATUS_OFF, 32'h0);
		chk(rd, exp_st(), "status");
	endtask : rd_st
	task automatic pulse(input int i);
		@(posedge pclk);
		ev[i] <= 1'b1;
		@(posedge pclk);
		ev <= 5'h00;
	endtask : pulse
	// Irq is registered: let two edges pass before looking
	task automatic chk_irq(input logic v);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, {31'h0, v}, "irq");
	endtask : chk_irq
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_sim
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite} = 3'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		lv = 8'h0a;
		ev = 5'h00;
		e_err = 2'h0;
		e_done = 2'h0;
		seed = 32'h9c0f;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd_st();
		apb(1'b0, codec_status_pkg::MASK_OFF, 32'h0);
		chk(rd, 32'h0000_00c0, "mask reset");
		chk_irq(1'b0);
		apb(1'b1, codec_status_pkg::STATUS_OFF, 32'h0000_00c0);
		$display("test reset done");
		// Levels: all-clear and all-set corners, then random
		for (int i = 0; i < 24; i++) begin
			seed = xs(seed);
			@(posedge pclk);
			lv <= (i < 2) ? {8{i[0]}} : seed[7:0];
			rd_st();
		end
		$display("test levels done");
		// Error flags: set, mask, unmask, clear by writing one
		for (int i = 0; i < 2; i++) begin
			pulse(i);
			e_err[i] = 1'b1;
			rd_st();
			chk_irq(1'b1);
			apb(1'b1, codec_status_pkg::MASK_OFF, 32'h0);
			chk_irq(1'b0);
			apb(1'b1, codec_status_pkg::MASK_OFF, 32'h0000_00c0);
			chk_irq(1'b1);
			apb(1'b1, codec_status_pkg::STATUS_OFF, 32'h40 << i);
			e_err[i] = 1'b0;
			rd_st();
			chk_irq(1'b0);
		end
		// Both set back to back; clear one, then all ones clears the rest
		pulse(0);
		pulse(1);
		apb(1'b1, codec_status_pkg::STATUS_OFF, 32'h0000_0040);
		e_err = 2'b10;
		rd_st();
		chk_irq(1'b1);
		apb(1'b1, codec_status_pkg::STATUS_OFF, 32'hffff_ffff);
		e_err = 2'b00;
		rd_st();
		chk_irq(1'b0);
		$display("test errors done");
		// Done flags: survive writes, cleared by data register access
		for (int i = 0; i < 2; i++) begin
			pulse(2 + i);
			e_done[i] = 1'b1;
			rd_st();
			apb(1'b1, codec_status_pkg::STATUS_OFF, 32'hffff_ff3f);
			rd_st();
			chk_irq(1'b0);
			pulse(4);
			e_done = 2'b00;
			rd_st();
		end
		$display("test done flags done");
		apb(1'b0, 12'h020, 32'h0);
		chk(rd, 32'h0, "unmapped data");
		chk({31'h0, err}, 32'h1, "unmapped error");
		$display("test unmapped done");
		end_sim();
	end
endmodule : tb_codec_port_status
